/* inc/cald_pkg.sv */
// Shared constants, register map and state type for the carrier acquisition lock detector
package cald_pkg;
  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // Register word addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SWEEP = 4'h1;
  localparam logic [ADDR_W-1:0] REG_DISC = 4'h2;
  localparam logic [ADDR_W-1:0] REG_AFC = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PH_PRE_ACQ = 4'h4;
  localparam logic [ADDR_W-1:0] REG_PH_PRE_TRK = 4'h5;
  localparam logic [ADDR_W-1:0] REG_INT_PRE = 4'h6;
  localparam logic [ADDR_W-1:0] REG_FL_PRE = 4'h7;
  localparam logic [ADDR_W-1:0] REG_DWELL = 4'h8;
  localparam logic [ADDR_W-1:0] REG_INIT = 4'h9;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hA;
  localparam logic [ADDR_W-1:0] REG_PH_ACC = 4'hB;
  localparam logic [ADDR_W-1:0] REG_FL_ACC = 4'hC;
  localparam logic [ADDR_W-1:0] REG_GAIN_ACC = 4'hD;
  localparam logic [ADDR_W-1:0] REG_FREQ_ERR = 4'hE;
  // Control register bit positions
  localparam int CTRL_UP_MODE = 0;
  localparam int CTRL_STEPPED = 1;
  localparam int CTRL_AFC_EN = 2;
  localparam int CTRL_UP_SWEEP = 3;
  localparam int CTRL_UP_TRK = 4;
  localparam int CTRL_UP_LOCK = 5;
  localparam int CTRL_FL_FREQ = 27;
  // Field positions
  localparam int SW_MANT_LSB = 0;
  localparam int SW_MANT_W = 4;
  localparam int SW_EXP_LSB = 4;
  localparam int SW_EXP_W = 5;
  localparam int SW_BIAS = 28;
  localparam int NCO_MSB = 39;
  localparam int SW_ALIGN = NCO_MSB - SW_BIAS - SW_MANT_W;
  localparam int DISC_DLY_LSB = 0;
  localparam int DISC_OFF_LSB = 4;
  localparam int DISC_SHF_LSB = 12;
  localparam int DWELL_LSB = 0;
  localparam int VER_N_LSB = 8;
  localparam int FLK_N_LSB = 12;
  // Data widths
  localparam int PH_W = 8;
  localparam int DISC_W = 9;
  localparam int FE_W = 10;
  localparam int ACC_W = 18;
  localparam int CNT_W = 11;
  localparam int Q_W = 12;
  localparam int GE_W = 8;
  localparam int AFCW_W = 8;
  localparam int DLY_DEPTH = 16;
  localparam int DLY_AW = 4;
  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SWEEP_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DISC_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] AFC_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PH_PRE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] INT_PRE_RST = 32'h0000_0400;
  localparam logic [DATA_W-1:0] FL_PRE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DWELL_RST = 32'h0000_1100;
  // Lock detector states
  typedef enum logic [1:0] {ST_SEARCH, ST_VERIFY, ST_FALSE, ST_LOCK} cald_state_t;
endpackage

/* hw/cald_dly.sv */
// Small sample memory with registered read data for the discriminator delay line
`timescale 1ns/1ps
module cald_dly #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH]; // Sample storage, no reset needed

  // Write port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read before write, so the oldest entry is still seen at full depth
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // cald_dly

/* hw/cald_acc.sv */
// Preloadable accumulator with sticky overflow flag
`timescale 1ns/1ps
module cald_acc #(
  parameter int W = 18,
  parameter int IW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic [W-1:0] pre,
  input wire logic add_en,
  input wire logic [IW-1:0] add,
  output logic [W-1:0] sum,
  output logic ovf
);
  logic [W:0] sum_next; // One extra bit catches the carry out

  // Carry out of the top bit is the overflow
  always_comb begin
    sum_next = {1'b0, sum} + (W+1)'(add);
  end

  // Preload wins over accumulation; overflow stays until reload
  always_ff @(posedge clk) begin
    if (rst) begin
      sum <= '0;
      ovf <= 1'b0;
    end else if (clr) begin
      sum <= pre;
      ovf <= 1'b0;
    end else if (add_en) begin
      sum <= sum_next[W-1:0];
      ovf <= ovf | sum_next[W];
    end
  end
endmodule // cald_acc

/* hw/cald_top.sv */
// Carrier acquisition: sweep, discriminator, AFC weight and lock detector
`timescale 1ns/1ps
module cald_top import cald_pkg::*; #(
  parameter int LAG_W = 40
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic PH_VLD,
  input wire logic signed [PH_W-1:0] PHASE_ERR,
  input wire logic END_BIT,
  input wire logic signed [Q_W-1:0] Q_FULL,
  input wire logic signed [Q_W-1:0] Q_HALF,
  input wire logic signed [GE_W-1:0] GAIN_ERR,
  input wire logic FILT_UPD,
  input wire logic LAG_AT_MAX,
  input wire logic LAG_AT_MIN,
  output logic [DATA_W-1:0] RDATA,
  output logic signed [LAG_W-1:0] LAG_INJECT,
  output logic LAG_INJ_VLD,
  output logic TRK_SEL,
  output logic LOCKED,
  output logic SWEEP_ON,
  output logic SWEEP_DOWN,
  output logic LOCK_PERIOD_IRQ,
  output logic signed [FE_W-1:0] FREQ_ERR
);
  // Magnitude of a sign-extended value; the most negative code maps to its true size
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Software visible configuration
  logic [DATA_W-1:0] ctrl_reg; // Mode and enable bits
  logic [DATA_W-1:0] sweep_reg; // Sweep mantissa and exponent
  logic [DATA_W-1:0] disc_reg; // Delay, offset and shift
  logic [DATA_W-1:0] afc_reg; // AFC weight
  logic [DATA_W-1:0] php_acq_reg; // Phase preload, acquisition set
  logic [DATA_W-1:0] php_trk_reg; // Phase preload, tracking set
  logic [DATA_W-1:0] intp_reg; // Integration count preload
  logic [DATA_W-1:0] flp_reg; // False lock preload
  logic [DATA_W-1:0] dwell_reg; // Dwell and period counts
  logic init_wr; // Restart request from software

  // Register writes; a write to the restart word stores nothing
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_reg <= CTRL_RST;
      sweep_reg <= SWEEP_RST;
      disc_reg <= DISC_RST;
      afc_reg <= AFC_RST;
      php_acq_reg <= PH_PRE_RST;
      php_trk_reg <= PH_PRE_RST;
      intp_reg <= INT_PRE_RST;
      flp_reg <= FL_PRE_RST;
      dwell_reg <= DWELL_RST;
    end else if (WR) begin
      case (ADDR)
        REG_CTRL: ctrl_reg <= WDATA;
        REG_SWEEP: sweep_reg <= WDATA;
        REG_DISC: disc_reg <= WDATA;
        REG_AFC: afc_reg <= WDATA;
        REG_PH_PRE_ACQ: php_acq_reg <= WDATA;
        REG_PH_PRE_TRK: php_trk_reg <= WDATA;
        REG_INT_PRE: intp_reg <= WDATA;
        REG_FL_PRE: flp_reg <= WDATA;
        REG_DWELL: dwell_reg <= WDATA;
        default: ; // Read-only and unmapped words ignore writes
      endcase
    end
  end

  assign init_wr = WR && (ADDR == REG_INIT);

  // Decoded control fields
  logic up_mode; // Processor makes the lock decisions
  logic stepped; // Stepped rather than swept acquisition
  logic afc_en; // AFC term reaches the lag path
  logic fl_freq; // False lock accumulator sums frequency error
  logic [SW_MANT_W-1:0] sw_mant;
  logic [SW_EXP_W-1:0] sw_exp;
  logic [3:0] dly_sel; // Discriminator delay minus one
  logic signed [7:0] fe_off;
  logic [3:0] fe_shf;
  logic [7:0] dwell_n; // Dwell symbols minus one
  logic [3:0] ver_n; // Verify periods needed for lock
  logic [3:0] flk_n; // Sweep periods spent in false lock

  assign up_mode = ctrl_reg[CTRL_UP_MODE];
  assign stepped = ctrl_reg[CTRL_STEPPED];
  assign afc_en = ctrl_reg[CTRL_AFC_EN];
  assign fl_freq = ctrl_reg[CTRL_FL_FREQ];
  assign sw_mant = sweep_reg[SW_MANT_LSB +: SW_MANT_W];
  assign sw_exp = sweep_reg[SW_EXP_LSB +: SW_EXP_W];
  assign dly_sel = disc_reg[DISC_DLY_LSB +: 4];
  assign fe_off = disc_reg[DISC_OFF_LSB +: 8];
  assign fe_shf = disc_reg[DISC_SHF_LSB +: 4];
  assign dwell_n = dwell_reg[DWELL_LSB +: 8];
  assign ver_n = dwell_reg[VER_N_LSB +: 4];
  assign flk_n = dwell_reg[FLK_N_LSB +: 4];

  // Discriminator delay line
  logic [DLY_AW-1:0] wp_reg; // Next write slot
  logic [DLY_AW-1:0] rd_addr;
  logic [PH_W-1:0] old_raw; // Delayed sample from the memory
  logic signed [PH_W-1:0] cur_reg; // Current sample, aligned to the read
  logic [4:0] fill_reg; // Samples written, saturating one past depth
  logic disc_vld_reg; // Delayed pair ready this cycle
  logic signed [PH_W-1:0] old_s;
  logic signed [DISC_W-1:0] disc;
  logic signed [FE_W-1:0] fe_sum;
  logic signed [FE_W-1:0] fe_reg; // Frequency error detector output

  // Full depth reads the slot being overwritten, which still holds the oldest sample
  assign rd_addr = wp_reg - DLY_AW'(dly_sel) - 4'h1;

  cald_dly #(.W(PH_W), .DEPTH(DLY_DEPTH), .AW(DLY_AW)) u_dly (
    .clk(CLK),
    .rst(SYS_RST),
    .wr_en(PH_VLD),
    .wr_addr(wp_reg),
    .wr_data(PHASE_ERR),
    .rd_en(PH_VLD),
    .rd_addr(rd_addr),
    .rd_data(old_raw)
  );

  // Write pointer, fill level and sample alignment
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wp_reg <= '0;
      fill_reg <= '0;
      cur_reg <= '0;
      disc_vld_reg <= 1'b0;
    end else begin
      disc_vld_reg <= PH_VLD;
      if (PH_VLD) begin
        wp_reg <= wp_reg + 4'h1;
        cur_reg <= PHASE_ERR;
        if (fill_reg != 5'h11) begin
          fill_reg <= fill_reg + 5'h01;
        end
      end
    end
  end

  // Unwritten slots count as zero so start-up never leaks unknown data
  always_comb begin
    old_s = (fill_reg > 5'({1'b0, dly_sel}) + 5'h01) ? signed'(old_raw) : '0;
    disc = DISC_W'(cur_reg) - DISC_W'(old_s);
    fe_sum = FE_W'(disc) + FE_W'(fe_off);
  end

  // Offset then arithmetic shift; both zero passes the difference through
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      fe_reg <= '0;
    end else if (disc_vld_reg) begin
      fe_reg <= fe_sum >>> fe_shf;
    end
  end

  assign FREQ_ERR = fe_reg;

  // Lock detector timing
  cald_state_t state_reg; // Lock detector state
  logic start_reg; // Forces the first load after reset
  logic running_reg; // Accumulators active
  logic [CNT_W-1:0] int_cnt_reg; // Integration counter
  logic [8:0] dwell_cnt_reg; // Remaining dwell symbols
  logic [3:0] per_cnt_reg; // Periods spent in verify or false lock
  logic acq; // Acquisition parameter set selected
  logic sweep_en;
  logic lock_now;
  logic fl_on; // False lock detection active
  logic cnt_zero;
  logic period_end;
  logic load;
  logic act; // End-bit sample that integrates
  logic ph_ovf;
  logic fl_ovf;
  logic [ACC_W-1:0] ph_sum;
  logic [ACC_W-1:0] fl_sum;
  logic [ACC_W-1:0] ge_sum;
  logic [ACC_W-1:0] ph_pre;
  logic [PH_W-1:0] ph_mag;
  logic [GE_W-1:0] ge_mag;
  logic [FE_W-1:0] fl_add;
  logic fl_flag;

  // Parameter set and sweep gating
  always_comb begin
    acq = up_mode ? ~ctrl_reg[CTRL_UP_TRK] : (state_reg == ST_SEARCH || state_reg == ST_FALSE);
    sweep_en = acq && (up_mode ? ctrl_reg[CTRL_UP_SWEEP] : 1'b1);
    lock_now = up_mode ? ctrl_reg[CTRL_UP_LOCK] : (state_reg == ST_LOCK);
    fl_on = up_mode || (state_reg != ST_LOCK);
    ph_pre = acq ? php_acq_reg[ACC_W-1:0] : php_trk_reg[ACC_W-1:0];
  end

  // Period ends on the earlier of overflow or count end
  assign cnt_zero = (int_cnt_reg == '0);
  assign period_end = running_reg && !start_reg && (ph_ovf || (fl_ovf && fl_on) || cnt_zero);
  assign load = start_reg || init_wr || (period_end && !up_mode);
  assign act = END_BIT && running_reg && !load && !cnt_zero && (dwell_cnt_reg == '0);

  // Sample magnitudes and false lock test
  always_comb begin
    ph_mag = PH_W'(mag16(16'(PHASE_ERR)));
    ge_mag = GE_W'(mag16(16'(GAIN_ERR)));
    fl_flag = mag16(16'(Q_FULL)) < mag16(16'(Q_HALF));
    fl_add = fl_freq ? FE_W'(mag16(16'(fe_reg))) : FE_W'(fl_flag);
  end

  cald_acc #(.W(ACC_W), .IW(PH_W)) u_ph_acc (
    .clk(CLK),
    .rst(SYS_RST),
    .clr(load),
    .pre(ph_pre),
    .add_en(act),
    .add(ph_mag),
    .sum(ph_sum),
    .ovf(ph_ovf)
  );

  cald_acc #(.W(ACC_W), .IW(FE_W)) u_fl_acc (
    .clk(CLK),
    .rst(SYS_RST),
    .clr(load),
    .pre(flp_reg[ACC_W-1:0]),
    .add_en(act && fl_on),
    .add(fl_add),
    .sum(fl_sum),
    .ovf(fl_ovf)
  );

  cald_acc #(.W(ACC_W), .IW(GE_W)) u_ge_acc (
    .clk(CLK),
    .rst(SYS_RST),
    .clr(load),
    .pre('0),
    .add_en(act),
    .add(ge_mag),
    .sum(ge_sum),
    .ovf()
  );

  // Start, run and halt; processor mode stops until restarted by software
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      start_reg <= 1'b1;
      running_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (load) begin
        running_reg <= 1'b1;
      end else if (period_end && up_mode) begin
        running_reg <= 1'b0;
      end
    end
  end

  // Integration counter, at most 2047 symbols
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      int_cnt_reg <= '0;
    end else if (load) begin
      int_cnt_reg <= intp_reg[CNT_W-1:0];
    end else if (act) begin
      int_cnt_reg <= int_cnt_reg - 11'h001;
    end
  end

  // Dwell holds off integration after each restart in stepped mode
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dwell_cnt_reg <= '0;
    end else if (load) begin
      dwell_cnt_reg <= stepped ? (9'({1'b0, dwell_n}) + 9'h001) : 9'h000;
    end else if (END_BIT && dwell_cnt_reg != '0) begin
      dwell_cnt_reg <= dwell_cnt_reg - 9'h001;
    end
  end

  // Completion interrupt; a period end beats a restart in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      LOCK_PERIOD_IRQ <= 1'b0;
    end else if (period_end && up_mode) begin
      LOCK_PERIOD_IRQ <= 1'b1;
    end else if (init_wr) begin
      LOCK_PERIOD_IRQ <= 1'b0;
    end
  end

  // Lock state machine, stepped once per integration period
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_SEARCH;
      per_cnt_reg <= '0;
    end else if (period_end && !up_mode) begin
      unique case (state_reg)
        ST_SEARCH: begin
          // No phase overflow ended the period: average error under threshold
          if (!ph_ovf) begin
            state_reg <= ST_VERIFY;
            per_cnt_reg <= '0;
          end
        end
        ST_VERIFY: begin
          if (ph_ovf) begin
            state_reg <= ST_SEARCH;
          end else if (fl_ovf) begin
            state_reg <= ST_FALSE;
            per_cnt_reg <= '0;
          end else if (per_cnt_reg + 4'h1 >= ver_n) begin
            state_reg <= ST_LOCK;
          end else begin
            per_cnt_reg <= per_cnt_reg + 4'h1;
          end
        end
        ST_FALSE: begin
          // Keep sweeping out of the false lock region
          if (per_cnt_reg + 4'h1 >= flk_n) begin
            state_reg <= ST_SEARCH;
          end else begin
            per_cnt_reg <= per_cnt_reg + 4'h1;
          end
        end
        ST_LOCK: begin
          if (ph_ovf) begin
            state_reg <= ST_SEARCH;
          end
        end
      endcase
    end
  end

  // Sweep direction flips at either lag limit
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SWEEP_DOWN <= 1'b0;
    end else if (sweep_en && LAG_AT_MAX) begin
      SWEEP_DOWN <= 1'b1;
    end else if (sweep_en && LAG_AT_MIN) begin
      SWEEP_DOWN <= 1'b0;
    end
  end

  // Lag path injection
  logic [63:0] step_wide;
  logic signed [LAG_W-1:0] step;
  logic signed [LAG_W-1:0] afc_term;
  logic signed [FE_W+AFCW_W-1:0] afc_prod;
  logic sw_fire;

  always_comb begin
    // Leading one sits at bit NCO_MSB minus (bias minus exponent)
    step_wide = 64'({1'b1, sw_mant}) << (7'(sw_exp) + 7'(SW_ALIGN));
    step = SWEEP_DOWN ? -LAG_W'(step_wide) : LAG_W'(step_wide);
    sw_fire = sweep_en && (stepped ? load : FILT_UPD);
    afc_prod = fe_reg * signed'(afc_reg[AFCW_W-1:0]);
    afc_term = (afc_en && FILT_UPD) ? LAG_W'(afc_prod) : '0;
  end

  // Sweep and AFC terms summed into one registered lag-path word
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      LAG_INJECT <= '0;
      LAG_INJ_VLD <= 1'b0;
    end else begin
      LAG_INJECT <= (sw_fire ? step : '0) + afc_term;
      LAG_INJ_VLD <= sw_fire || FILT_UPD;
    end
  end

  // Registered status outputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      TRK_SEL <= 1'b0;
      LOCKED <= 1'b0;
      SWEEP_ON <= 1'b0;
    end else begin
      TRK_SEL <= ~acq;
      LOCKED <= lock_now;
      SWEEP_ON <= sweep_en;
    end
  end

  // Read data for one cycle only, zero otherwise and for unmapped words
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        REG_CTRL: RDATA <= ctrl_reg;
        REG_SWEEP: RDATA <= sweep_reg;
        REG_DISC: RDATA <= disc_reg;
        REG_AFC: RDATA <= afc_reg;
        REG_PH_PRE_ACQ: RDATA <= php_acq_reg;
        REG_PH_PRE_TRK: RDATA <= php_trk_reg;
        REG_INT_PRE: RDATA <= intp_reg;
        REG_FL_PRE: RDATA <= flp_reg;
        REG_DWELL: RDATA <= dwell_reg;
        REG_STATUS: RDATA <= 32'({fl_ovf, ph_ovf, running_reg, LOCK_PERIOD_IRQ, SWEEP_DOWN,
                                  LOCKED, TRK_SEL, state_reg});
        REG_PH_ACC: RDATA <= 32'(ph_sum);
        REG_FL_ACC: RDATA <= 32'(fl_sum);
        REG_GAIN_ACC: RDATA <= 32'(ge_sum);
        REG_FREQ_ERR: RDATA <= 32'(unsigned'(fe_reg));
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end
endmodule // cald_top

/* sim/cald_asserts.sv */
// Port checker for the carrier acquisition lock detector
`timescale 1ns/1ps
module cald_asserts import cald_pkg::*; (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic PH_VLD,
  input wire logic FILT_UPD,
  input wire logic LAG_AT_MAX,
  input wire logic LAG_AT_MIN,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic LAG_INJ_VLD,
  input wire logic TRK_SEL,
  input wire logic LOCKED,
  input wire logic SWEEP_ON,
  input wire logic SWEEP_DOWN,
  input wire logic LOCK_PERIOD_IRQ,
  input wire logic signed [FE_W-1:0] FREQ_ERR
);
  // One clock domain, so one clocking and one reset qualifier
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Read data stands only in the cycle after a read
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not idle");
  // Status word mirrors the levels seen at the read edge
  status_read_a: assert property (RD && ADDR == REG_STATUS |=>
    RDATA[5:2] == {$past(LOCK_PERIOD_IRQ), $past(SWEEP_DOWN), $past(LOCKED), $past(TRK_SEL)})
    else $error("status word wrong");
  // Settled tracking never sweeps; one cycle of slack for the handover
  sweep_trk_a: assert property (TRK_SEL && $past(TRK_SEL) |-> !SWEEP_ON)
    else $error("sweep while tracking");
  // Upper limit turns the sweep downward, and it wins over the lower one
  sweep_down_a: assert property (SWEEP_ON && LAG_AT_MAX |=> SWEEP_DOWN)
    else $error("no turn at upper limit");
  sweep_up_a: assert property (SWEEP_ON && LAG_AT_MIN && !LAG_AT_MAX |=> !SWEEP_DOWN)
    else $error("no turn at lower limit");
  // Every filter output is answered by an injection next cycle
  inj_follow_a: assert property (FILT_UPD |=> LAG_INJ_VLD)
    else $error("filter update without injection");
  // Period flag holds until a restart command
  irq_hold_a: assert property (LOCK_PERIOD_IRQ && !(WR && ADDR == REG_INIT) |=>
    LOCK_PERIOD_IRQ)
    else $error("period flag dropped");
  // Leaving reset: search, acquisition set, sweeping up
  reset_state_a: assert property ($fell(SYS_RST) |->
    !TRK_SEL && !LOCKED && !SWEEP_DOWN && !LOCK_PERIOD_IRQ)
    else $error("bad state after reset");
  // Error output moves only two cycles after a phase sample
  fe_pipe_a: assert property ($changed(FREQ_ERR) |-> $past(PH_VLD, 2))
    else $error("frequency error moved unprompted");
  lock_seen_c: cover property ($rose(LOCKED));
  turn_seen_c: cover property ($rose(SWEEP_DOWN));
  irq_seen_c: cover property ($rose(LOCK_PERIOD_IRQ));
endmodule // cald_asserts
bind cald_top cald_asserts i_cald_asserts (.CLK, .SYS_RST, .ADDR, .WR, .RD, .PH_VLD, .FILT_UPD,
  .LAG_AT_MAX, .LAG_AT_MIN, .RDATA, .LAG_INJ_VLD, .TRK_SEL, .LOCKED, .SWEEP_ON, .SWEEP_DOWN,
  .LOCK_PERIOD_IRQ, .FREQ_ERR);

/* sim/cald_partner.sv */
// Behavioural carrier loop filter: lag accumulator, output pacing, limit flags
`timescale 1ns/1ps
module cald_partner #(
  parameter longint LIM_HI = 100000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic signed [39:0] inj,
  input wire logic inj_vld,
  output logic filt_upd,
  output logic at_max,
  output logic at_min
);
  logic signed [39:0] lag_reg; // Lag accumulator
  logic [1:0] div_reg; // One filter output every four clocks
  // Lag takes every injection offered, even while not pacing
  always_ff @(posedge clk) begin
    if (rst) begin
      lag_reg <= 40'sh0;
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (inj_vld) begin
        lag_reg <= lag_reg + inj;
      end
    end
  end
  // New outputs only while the loop runs
  assign filt_upd = run && (div_reg == 2'h3);
  // Lower limit at zero, so a sweep from reset starts on it
  assign at_max = lag_reg >= LIM_HI;
  assign at_min = lag_reg <= 40'sh0;
endmodule // cald_partner

/* sim/cald_top_bench.sv */
// Self-checking bench for the carrier acquisition lock detector
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module cald_top_bench import cald_pkg::*; ;
  logic clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, ph_vld = 1'b0, end_bit = 1'b0;
  logic run = 1'b0; // Partner pacing enable
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 32'h0, rdv, rdata;
  logic signed [PH_W-1:0] phase_err = 8'sh0;
  logic signed [Q_W-1:0] q_full = 12'sh0, q_half = 12'sh0;
  logic signed [GE_W-1:0] gain_err = 8'sh0;
  logic filt_upd, at_max, at_min, inj_vld, trk_sel, locked, sweep_on, sweep_down, irq;
  logic signed [39:0] lag_inject, step;
  logic signed [FE_W-1:0] freq_err;
  int num_errors = 0, compares = 0, cyc = 0;
  // Register rows: address, word written, word read back (refused places among them)
  logic [ADDR_W-1:0] ra[7] = '{REG_SWEEP, REG_AFC, REG_FL_PRE, REG_STATUS, REG_INIT, 4'hF,
    REG_PH_PRE_TRK};
  logic [DATA_W-1:0] rw[7] = '{32'h155, 32'hA5, 32'h3FFFF, 32'hFF, 32'h1, 32'hFFFF, 32'h2ABCD};
  logic [DATA_W-1:0] re[7] = '{32'h155, 32'hA5, 32'h3FFFF, 32'h40, 32'h0, 32'h0, 32'h2ABCD};
  // Phase samples and the error each should give
  logic signed [PH_W-1:0] pv[5] = '{8'sh03, 8'sh0A, 8'sh1E, 8'sh46, 8'shCE};
  logic signed [FE_W-1:0] fv[5] = '{10'sh003, 10'sh00A, 10'sh01B, 10'sh020, 10'sh3DA};
  always #20 clk = ~clk;
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  cald_top i_cald_top (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .PH_VLD(ph_vld), .PHASE_ERR(phase_err), .END_BIT(end_bit), .Q_FULL(q_full),
    .Q_HALF(q_half), .GAIN_ERR(gain_err), .FILT_UPD(filt_upd), .LAG_AT_MAX(at_max),
    .LAG_AT_MIN(at_min), .RDATA(rdata), .LAG_INJECT(lag_inject), .LAG_INJ_VLD(inj_vld),
    .TRK_SEL(trk_sel), .LOCKED(locked), .SWEEP_ON(sweep_on), .SWEEP_DOWN(sweep_down),
    .LOCK_PERIOD_IRQ(irq), .FREQ_ERR(freq_err));
  cald_partner i_cald_partner (.clk(clk), .rst(sys_rst), .run(run), .inj(lag_inject),
    .inj_vld(inj_vld), .filt_upd(filt_upd), .at_max(at_max), .at_min(at_min));
  // One-cycle write strobe
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read strobe, data taken mid-cycle after it
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  function automatic logic flag(input int sel);
    return sel == 0 ? trk_sel : sel == 1 ? locked : sel == 2 ? !locked : sel == 3 ? irq : 1'b0;
  endfunction
  // End-bit pulses until the chosen flag is seen, bounded
  task automatic eb_until(input int sel, input int lim);
    for (int i = 0; i < lim && flag(sel) !== 1'b1; i++) begin
      @(posedge clk);
      end_bit <= 1'b1;
      @(posedge clk);
      end_bit <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
    end
  endtask
  task automatic wait_inj();
    @(negedge clk);
    for (int i = 0; i < 60 && inj_vld !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic conclude();
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(REG_INT_PRE, rdv);
    `CHK("int_pre", INT_PRE_RST, rdv)
    rd_reg(REG_DWELL, rdv);
    `CHK("dwell", DWELL_RST, rdv)
    rd_reg(REG_STATUS, rdv);
    `CHK("status", 32'h40, rdv)
    `CHK("sweep_on", 1'b1, sweep_on)
    foreach (ra[k]) begin
      wr_reg(ra[k], rw[k]);
      rd_reg(ra[k], rdv);
      `CHK("reg", re[k], rdv)
    end
    // Two-sample delay, then offset 5 and shift 1 from the fourth sample on
    wr_reg(REG_DISC, 32'h0001);
    foreach (pv[k]) begin
      if (k == 3) begin
        wr_reg(REG_DISC, 32'h1051);
      end
      @(posedge clk);
      ph_vld <= 1'b1;
      phase_err <= pv[k];
      @(posedge clk);
      ph_vld <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      `CHK("freq_err", fv[k], freq_err)
    end
    // Swept search with 01.0101 at exponent 3; weight -91 on error -38 adds D82
    step = 40'sh15 <<< (3 + SW_ALIGN);
    wr_reg(REG_SWEEP, 32'h035);
    wr_reg(REG_CTRL, 32'h4);
    run <= 1'b1;
    wait_inj();
    `CHK("step_up", step + 40'shD82, lag_inject)
    for (int i = 0; i < 400 && sweep_down !== 1'b1; i++) @(negedge clk);
    wait_inj();
    `CHK("step_down", -step + 40'shD82, lag_inject)
    @(posedge clk);
    run <= 1'b0;
    // Automatic control: clean periods go through verify to lock
    wr_reg(REG_FL_PRE, 32'h0);
    wr_reg(REG_INT_PRE, 32'h3);
    phase_err <= 8'sh02;
    q_full <= 12'sh064;
    q_half <= 12'sh00A;
    gain_err <= 8'sh01;
    wr_reg(REG_INIT, 32'h1);
    eb_until(0, 40);
    `CHK("trk_sel", 1'b1, trk_sel)
    eb_until(1, 40);
    `CHK("locked", 1'b1, locked)
    `CHK("sweep_lock", 1'b0, sweep_on)
    // Large errors on a near-full preload overflow on the last symbol of the count
    wr_reg(REG_PH_PRE_TRK, 32'h3FF00);
    phase_err <= 8'sh7F;
    eb_until(2, 40);
    repeat (2) @(negedge clk);
    `CHK("trk_drop", 1'b0, trk_sel)
    rd_reg(REG_STATUS, rdv);
    `CHK("state", 2'h0, rdv[1:0])
    // Processor control, stepped: halt and flag at period end
    wr_reg(REG_CTRL, 32'h0000000B);
    wr_reg(REG_PH_PRE_ACQ, 32'h64);
    wr_reg(REG_INT_PRE, 32'h4);
    phase_err <= 8'shFB;
    gain_err <= 8'shFD;
    q_full <= 12'sh00A;
    q_half <= 12'shFEC;
    wr_reg(REG_INIT, 32'h1);
    wait_inj();
    `CHK("step_load", -step, lag_inject)
    eb_until(3, 40);
    rd_reg(REG_PH_ACC, rdv);
    `CHK("ph_acc", 32'h78, rdv)
    rd_reg(REG_GAIN_ACC, rdv);
    `CHK("gain_acc", 32'hC, rdv)
    rd_reg(REG_FL_ACC, rdv);
    `CHK("fl_acc", 32'h4, rdv)
    eb_until(4, 3);
    rd_reg(REG_PH_ACC, rdv);
    `CHK("ph_hold", 32'h78, rdv)
    `CHK("irq", 1'b1, irq)
    wr_reg(REG_INIT, 32'h1);
    @(negedge clk);
    `CHK("irq_clr", 1'b0, irq)
    // False-lock accumulator summing the error magnitude instead
    wr_reg(REG_CTRL, 32'h0800000B);
    wr_reg(REG_INIT, 32'h1);
    eb_until(3, 40);
    rd_reg(REG_FL_ACC, rdv);
    `CHK("fl_freq", 32'h98, rdv)
    // Reset in mid-run
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK("irq_rst", 1'b0, irq)
    `CHK("down_rst", 1'b0, sweep_down)
    conclude();
  end
endmodule // cald_top_bench
